/* File: brk_pkg.sv */
// Package holding register map, field positions, reset values and opcodes of the breakpoint unit.
package brk_pkg;
    localparam logic [2:0] ADDR_CONTROL_STATUS = 3'h0;
    localparam logic [2:0] ADDR_BKPT_HIGH      = 3'h1;
    localparam logic [2:0] ADDR_BKPT_LOW       = 3'h2;
    localparam logic [2:0] ADDR_LOWPOWER_STAT  = 3'h3;
    localparam logic [2:0] ADDR_FLAG_CLEAR     = 3'h4;
    localparam logic [2:0] ADDR_IRQ_STATUS     = 3'h5;
    localparam logic [2:0] ADDR_IRQ_MASK       = 3'h6;
    localparam int BIT_MATCH_ENABLE  = 7;
    localparam int BIT_ACTIVE_FLAG   = 6;
    localparam int BIT_LOWPOWER_EXIT = 1;
    localparam int BIT_CLEAR_PERMIT  = 7;
    localparam int BIT_EV_BREAK      = 0;
    localparam int BIT_EV_WAKE       = 1;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] SOFTWARE_INTERRUPT_OPCODE = 8'h83;
    localparam logic [15:0] VECTOR_NORMAL  = 16'hfffc;
    localparam logic [15:0] VECTOR_MONITOR = 16'hfefc;
    localparam int UNMAPPED_READ = 0;
endpackage : brk_pkg

/* File: brk_match.sv */
// Address comparator that detects a breakpoint hit.
`timescale 1ns/1ps
module brk_match #(
    parameter int AW = 16
) (
    input  wire logic [AW-1:0] cpu_addr,   // Address driven by the CPU.
    input  wire logic [AW-1:0] bkpt_addr,  // Programmed breakpoint.
    input  wire logic          enable,     // Match enable.
    output logic               hit         // Qualified match.
);
    // Refuse a width that leaves nothing to compare.
    if (AW < 1) begin : g_bad_width
        $error("AW must be positive.");
    end
    // The compare is combinational so a hit on an instruction's last cycle is seen at once.
    assign hit = enable && (cpu_addr == bkpt_addr);
endmodule : brk_match

/* File: brk_unit.sv */
// Breakpoint unit: registers, break request, freeze and low-power flag logic.
//
// The placing of the registers and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ps
// A break starts from one of two sources: the CPU address equal to the programmed
// breakpoint while matching is enabled, or software writing one to the active flag.
// Either source becomes a request that waits for the end of the instruction in
// progress; a source that lands on an instruction's last cycle is taken at once.
// In stop mode the core executes nothing, so a request is taken without a boundary
// and the stop exit pulse wakes the part.
// The break state runs from the take until the CPU reports a return from interrupt.
// While it runs, the timers are frozen, the watchdog is gated when the test level is
// present, and status clearing follows the permit bit.
// Sources that arrive while a break runs set the active flag but start no new break,
// so a breakpoint inside the break routine cannot nest.
// All outputs come from flops, which costs one cycle of latency toward the CPU but
// keeps the long routes to the timers and the watchdog free of decode glitches.
module brk_unit (
    input  wire logic        CLK,             // 20 MHz clock.
    input  wire logic        RST,             // Synchronous reset, high.
    input  wire logic [2:0]  ADDR,            // Register address.
    input  wire logic [7:0]  WDATA,           // Register write data.
    input  wire logic        WR,              // Write strobe.
    input  wire logic        RD,              // Read strobe.
    output logic      [7:0]  RDATA,           // Read data, one cycle after RD.
    input  wire logic [15:0] CPU_ADDR,        // CPU internal address bus.
    input  wire logic        INSTR_LAST,      // Final cycle of the current instruction.
    input  wire logic        RTI_DONE,        // Return from interrupt executed.
    input  wire logic        MONITOR_MODE,    // Monitor mode selects the alternate vector.
    input  wire logic        WAIT_MODE,       // CPU in wait mode.
    input  wire logic        STOP_MODE,       // CPU in stop mode.
    input  wire logic        TEST_VOLTAGE,    // Test voltage level on reset pin.
    output logic             BREAK_REQ,       // Break request to CPU.
    output logic             BREAK_TAKE,      // One-cycle pulse: CPU starts the break now.
    output logic      [7:0]  BREAK_OPCODE,    // Opcode to load into instruction register.
    output logic      [15:0] BREAK_VECTOR,    // Vector address for the break.
    output logic             IN_BREAK,        // Break state in progress.
    output logic             TIMER_FREEZE,    // Halts all timer counters.
    output logic             WATCHDOG_OFF,    // Disables the watchdog.
    output logic             STOP_EXIT,       // Pulse waking the part from stop.
    output logic             CLEAR_PERMIT,    // Status clearing allowed.
    output logic             IRQ              // Level interrupt.
);
    logic        match_enable;
    logic        active_flag;
    logic [7:0]  bkpt_high;
    logic [7:0]  bkpt_low;
    logic        lowpower_exit;
    logic        permit;
    logic        pending;
    logic        in_break;
    logic [1:0]  irq_status;
    logic [1:0]  irq_mask;
    logic        hit;

    // One register select, shared by every write strobe below.
    function automatic logic reg_write(input logic       strobe,
                                       input logic [2:0] addr,
                                       input logic [2:0] target);
        reg_write = strobe && (addr == target);
    endfunction : reg_write

    // Decoded write strobes; unmapped offsets decode to nothing, so such writes are lost.
    wire wr_ctrl  = reg_write(WR, ADDR, brk_pkg::ADDR_CONTROL_STATUS);
    wire wr_high  = reg_write(WR, ADDR, brk_pkg::ADDR_BKPT_HIGH);
    wire wr_low   = reg_write(WR, ADDR, brk_pkg::ADDR_BKPT_LOW);
    wire wr_lp    = reg_write(WR, ADDR, brk_pkg::ADDR_LOWPOWER_STAT);
    wire wr_fc    = reg_write(WR, ADDR, brk_pkg::ADDR_FLAG_CLEAR);
    wire wr_istat = reg_write(WR, ADDR, brk_pkg::ADDR_IRQ_STATUS);
    wire wr_imask = reg_write(WR, ADDR, brk_pkg::ADDR_IRQ_MASK);
    wire sw_break = wr_ctrl && WDATA[brk_pkg::BIT_ACTIVE_FLAG];
    // Matching runs regardless of wait mode; wait only gates the CPU, not this unit.
    wire trigger  = (hit || sw_break) && !in_break;
    wire req_now  = pending || trigger;
    // Take at the instruction boundary; a hit on the last cycle is taken at once.
    // In stop the core is idle, so the request is honoured without a boundary.
    wire take     = req_now && (INSTR_LAST || STOP_MODE);
    wire wake     = take && (WAIT_MODE || STOP_MODE);

    brk_match #(.AW(16)) u_match (
        .cpu_addr  (CPU_ADDR),
        .bkpt_addr ({bkpt_high, bkpt_low}),
        .enable    (match_enable),
        .hit       (hit)
    );

    // Match enable; cleared by reset so a part fresh out of reset never breaks by itself.
    always_ff @(posedge CLK) begin
        if (RST) begin
            match_enable <= 1'b0;
        end else if (wr_ctrl) begin
            match_enable <= WDATA[brk_pkg::BIT_MATCH_ENABLE];
        end
    end

    // Breakpoint high byte.
    always_ff @(posedge CLK) begin
        if (RST) begin
            bkpt_high <= brk_pkg::RESET_BYTE;
        end else if (wr_high) begin
            bkpt_high <= WDATA;
        end
    end

    // Breakpoint low byte. The two bytes are written one at a time, so software should
    // clear the enable first: a half-written address could match on the way.
    always_ff @(posedge CLK) begin
        if (RST) begin
            bkpt_low <= brk_pkg::RESET_BYTE;
        end else if (wr_low) begin
            bkpt_low <= WDATA;
        end
    end

    // Status clear permit bit.
    always_ff @(posedge CLK) begin
        if (RST) begin
            permit <= 1'b0;
        end else if (wr_fc) begin
            permit <= WDATA[brk_pkg::BIT_CLEAR_PERMIT];
        end
    end

    // Interrupt mask, same layout as the status.
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_mask <= 2'h0;
        end else if (wr_imask) begin
            irq_mask <= WDATA[1:0];
        end
    end

    // Active flag: a match sets it; writing zero clears it, but a set in the same cycle wins.
    always_ff @(posedge CLK) begin
        if (RST) begin
            active_flag <= 1'b0;
        end else if (hit || sw_break) begin
            active_flag <= 1'b1;
        end else if (wr_ctrl && !WDATA[brk_pkg::BIT_ACTIVE_FLAG]) begin
            active_flag <= 1'b0;
        end
    end

    // Request stays pending until the CPU reaches a boundary.
    always_ff @(posedge CLK) begin
        if (RST) begin
            pending <= 1'b0;
        end else begin
            pending <= req_now && !take;
        end
    end

    // Break state lasts from take until return from interrupt.
    always_ff @(posedge CLK) begin
        if (RST) begin
            in_break <= 1'b0;
        end else if (take) begin
            in_break <= 1'b1;
        end else if (RTI_DONE) begin
            in_break <= 1'b0;
        end
    end

    // Low-power exit flag; set wins over a write of zero.
    always_ff @(posedge CLK) begin
        if (RST) begin
            lowpower_exit <= 1'b0;
        end else if (wake) begin
            lowpower_exit <= 1'b1;
        end else if (wr_lp && !WDATA[brk_pkg::BIT_LOWPOWER_EXIT]) begin
            lowpower_exit <= 1'b0;
        end
    end

    // Sticky interrupt status, cleared by writing one; new events win.
    wire [1:0] events = {wake, take};
    always_ff @(posedge CLK) begin
        if (RST) begin
            irq_status <= 2'h0;
        end else begin
            irq_status <= events | (irq_status & ~(wr_istat ? WDATA[1:0] : 2'h0));
        end
    end

    // Read data mux.
    logic [7:0] rd_mux;
    always_comb begin
        rd_mux = 8'h00;
        case (ADDR)
            brk_pkg::ADDR_CONTROL_STATUS: begin
                rd_mux[brk_pkg::BIT_MATCH_ENABLE] = match_enable;
                rd_mux[brk_pkg::BIT_ACTIVE_FLAG]  = active_flag;
            end
            brk_pkg::ADDR_BKPT_HIGH:     rd_mux = bkpt_high;
            brk_pkg::ADDR_BKPT_LOW:      rd_mux = bkpt_low;
            brk_pkg::ADDR_LOWPOWER_STAT: rd_mux[brk_pkg::BIT_LOWPOWER_EXIT] = lowpower_exit;
            brk_pkg::ADDR_FLAG_CLEAR:    rd_mux[brk_pkg::BIT_CLEAR_PERMIT] = permit;
            brk_pkg::ADDR_IRQ_STATUS:    rd_mux[1:0] = irq_status;
            brk_pkg::ADDR_IRQ_MASK:      rd_mux[1:0] = irq_mask;
            default:                     rd_mux = 8'h00;
        endcase
    end

    // Next values of the registered outputs. The take cycle already counts as break
    // state, so the freeze begins together with the take pulse.
    wire        break_now      = (in_break || take) && !RTI_DONE;
    wire [7:0]  next_rdata     = RD ? rd_mux : 8'h00;
    // The request shows only cycles still waiting, so it falls as the take pulse rises.
    wire        next_break_req = req_now && !take;
    wire [15:0] next_vector    = MONITOR_MODE ? brk_pkg::VECTOR_MONITOR
                                              : brk_pkg::VECTOR_NORMAL;
    wire        next_watchdog  = break_now && TEST_VOLTAGE;
    wire        next_stop_exit = take && STOP_MODE;
    wire        next_permit    = permit && break_now;
    wire        next_irq       = |(irq_status & irq_mask);

    // Read data stand for one cycle after the strobe and are zero otherwise.
    always_ff @(posedge CLK) begin
        if (RST) begin
            RDATA <= 8'h00;
        end else begin
            RDATA <= next_rdata;
        end
    end

    // Request toward the CPU, held while the break waits for a boundary.
    always_ff @(posedge CLK) begin
        if (RST) begin
            BREAK_REQ <= 1'b0;
        end else begin
            BREAK_REQ <= next_break_req;
        end
    end

    // Take pulse; the CPU sees it one cycle after the qualifying boundary cycle.
    always_ff @(posedge CLK) begin
        if (RST) begin
            BREAK_TAKE <= 1'b0;
        end else begin
            BREAK_TAKE <= take;
        end
    end

    // Opcode and vector that the CPU loads when it starts the break.
    always_ff @(posedge CLK) begin
        if (RST) begin
            BREAK_OPCODE <= brk_pkg::SOFTWARE_INTERRUPT_OPCODE;
            BREAK_VECTOR <= brk_pkg::VECTOR_NORMAL;
        end else begin
            BREAK_OPCODE <= brk_pkg::SOFTWARE_INTERRUPT_OPCODE;
            BREAK_VECTOR <= next_vector;
        end
    end

    // Break state and timer freeze; the freeze has its own flop so that the long route
    // to the timers does not load the state output.
    always_ff @(posedge CLK) begin
        if (RST) begin
            IN_BREAK     <= 1'b0;
            TIMER_FREEZE <= 1'b0;
        end else begin
            IN_BREAK     <= break_now;
            TIMER_FREEZE <= break_now;
        end
    end

    // Watchdog gate; without the test level the watchdog keeps running in a break.
    always_ff @(posedge CLK) begin
        if (RST) begin
            WATCHDOG_OFF <= 1'b0;
        end else begin
            WATCHDOG_OFF <= next_watchdog;
        end
    end

    // Wake pulse out of stop.
    always_ff @(posedge CLK) begin
        if (RST) begin
            STOP_EXIT <= 1'b0;
        end else begin
            STOP_EXIT <= next_stop_exit;
        end
    end

    // Status clear permit, granted only inside a break and dropped with the return.
    always_ff @(posedge CLK) begin
        if (RST) begin
            CLEAR_PERMIT <= 1'b0;
        end else begin
            CLEAR_PERMIT <= next_permit;
        end
    end

    // Level interrupt, high while an unmasked status bit is set.
    always_ff @(posedge CLK) begin
        if (RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= next_irq;
        end
    end
endmodule : brk_unit

/* File: brk_checker.sv */
// Concurrent checks on the breakpoint unit ports.
`timescale 1ns/1ps
module brk_checker (
    input wire logic        CLK, RST, INSTR_LAST, RTI_DONE, MONITOR_MODE, // Inputs seen.
    input wire logic        STOP_MODE, TEST_VOLTAGE, BREAK_REQ, BREAK_TAKE, // Mixed.
    input wire logic [7:0]  BREAK_OPCODE, // Opcode out.
    input wire logic [15:0] BREAK_VECTOR, // Vector out.
    input wire logic        IN_BREAK, TIMER_FREEZE, WATCHDOG_OFF, STOP_EXIT, CLEAR_PERMIT // Out.
);
    // One clock domain, so clocking and reset are declared once.
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);
    a_take_on_last: assert property (BREAK_REQ && INSTR_LAST |=> BREAK_TAKE)
        else $error("Pending break not taken at instruction end.");
    a_req_held: assert property (BREAK_REQ && !INSTR_LAST && !STOP_MODE |=> BREAK_REQ)
        else $error("Break request dropped before it was taken.");
    a_take_enters: assert property (BREAK_TAKE |-> IN_BREAK)
        else $error("Break taken without break state.");
    a_freeze_tracks: assert property (TIMER_FREEZE == IN_BREAK)
        else $error("Timer freeze differs from break state.");
    a_watchdog_gate: assert property (IN_BREAK && $past(IN_BREAK) && $stable(TEST_VOLTAGE)
        |-> WATCHDOG_OFF == TEST_VOLTAGE)
        else $error("Watchdog gate wrong during break.");
    a_rti_ends: assert property (RTI_DONE && IN_BREAK |-> ##[1:2] !IN_BREAK)
        else $error("Break state outlived return from interrupt.");
    a_opcode_fixed: assert property (BREAK_OPCODE == brk_pkg::SOFTWARE_INTERRUPT_OPCODE)
        else $error("Break opcode wrong.");
    a_vector_mode: assert property (!$past(RST) |-> BREAK_VECTOR == ($past(MONITOR_MODE)
        ? brk_pkg::VECTOR_MONITOR : brk_pkg::VECTOR_NORMAL))
        else $error("Break vector does not follow monitor mode.");
    a_stop_exit: assert property (STOP_EXIT |-> IN_BREAK && $past(STOP_MODE))
        else $error("Stop exit without a break taken in stop.");
    a_permit_gate: assert property (CLEAR_PERMIT |-> IN_BREAK)
        else $error("Clear permit outside break.");
    c_req: cover property (BREAK_REQ ##1 BREAK_TAKE);
    c_stop: cover property (STOP_EXIT);
    c_rti: cover property (RTI_DONE && IN_BREAK);
endmodule : brk_checker
bind brk_unit brk_checker chk_i (.CLK(CLK), .RST(RST), .INSTR_LAST(INSTR_LAST),
    .RTI_DONE(RTI_DONE), .MONITOR_MODE(MONITOR_MODE), .STOP_MODE(STOP_MODE),
    .TEST_VOLTAGE(TEST_VOLTAGE), .BREAK_REQ(BREAK_REQ), .BREAK_TAKE(BREAK_TAKE),
    .BREAK_OPCODE(BREAK_OPCODE), .BREAK_VECTOR(BREAK_VECTOR), .IN_BREAK(IN_BREAK),
    .TIMER_FREEZE(TIMER_FREEZE), .WATCHDOG_OFF(WATCHDOG_OFF), .STOP_EXIT(STOP_EXIT),
    .CLEAR_PERMIT(CLEAR_PERMIT));

/* File: cpu_model.sv */
// Behavioural CPU core: three-cycle instructions, break vectoring and return.
`timescale 1ns/1ps
module cpu_model (
    input  wire logic        CLK,    // Clock.
    input  wire logic        RST,    // Reset.
    input  wire logic        take,   // Break taken.
    input  wire logic [15:0] vector, // Break vector.
    input  wire logic        ret,    // Run a return at the next boundary.
    output logic      [15:0] pc,     // Fetch address.
    output logic             last,   // Final cycle of an instruction.
    output logic             return_from_interrupt     // Return executed.
);
    logic [1:0]  cnt;
    logic [15:0] saved;
    assign last = (cnt == 2'h2);
    // Address moves at boundaries, on a take and one cycle after a return's boundary, so a match mid-instruction must wait.
    always_ff @(posedge CLK) begin
        if (RST) begin
            cnt <= 2'h0;
            pc  <= 16'h0000;
            return_from_interrupt <= 1'b0;
        end else begin
            cnt <= last ? 2'h0 : cnt + 2'h1;
            return_from_interrupt <= ret && last;
            if (take) begin
                saved <= pc;
                pc    <= vector;
            end else if (return_from_interrupt) pc <= saved;
            else if (last) pc <= pc + 16'h0001;
        end
    end
endmodule : cpu_model

/* File: address_breakpoint_unit_test.sv */
// Self-checking bench for the breakpoint unit with a CPU model.
`timescale 1ns/1ps
module address_breakpoint_unit_test;
    logic CLK = 0, RST = 1, WR = 0, RD = 0, MON = 0, WAIT_M = 0, STOP_M = 0, TV = 0, RET = 0;
    logic [2:0] ADDR = 3'h0;
    logic [7:0] WDATA = 8'h00, RDATA, OPC;
    logic [15:0] PC, VEC;
    logic LAST, RETURN_FROM_INTERRUPT, REQ, TAKE, INB, FRZ, WOFF, SEXIT, PERM, IRQ;
    int fails = 0, cmp_count = 0, i;
    localparam logic [18:0] ROWS [6] = '{{3'h1, 8'h00, 8'h00}, {3'h2, 8'h40, 8'h40},
        {3'h4, 8'h80, 8'h80}, {3'h6, 8'h03, 8'h03}, {3'h7, 8'h55, 8'h00}, {3'h0, 8'h80, 8'h80}};
    brk_unit dut (.CLK(CLK), .RST(RST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .CPU_ADDR(PC), .INSTR_LAST(LAST), .RTI_DONE(RETURN_FROM_INTERRUPT), .MONITOR_MODE(MON),
        .WAIT_MODE(WAIT_M), .STOP_MODE(STOP_M), .TEST_VOLTAGE(TV), .BREAK_REQ(REQ),
        .BREAK_TAKE(TAKE), .BREAK_OPCODE(OPC), .BREAK_VECTOR(VEC), .IN_BREAK(INB),
        .TIMER_FREEZE(FRZ), .WATCHDOG_OFF(WOFF), .STOP_EXIT(SEXIT), .CLEAR_PERMIT(PERM),
        .IRQ(IRQ));
    cpu_model cpu (.CLK(CLK), .RST(RST), .take(TAKE), .vector(VEC), .ret(RET), .pc(PC),
        .last(LAST), .return_from_interrupt(RETURN_FROM_INTERRUPT));
    // Clock at 50 ns period.
    initial forever #25 CLK = ~CLK;
    task chk(input string n, input logic [15:0] s, input logic [15:0] e);
        cmp_count++;
        if (s !== e) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    task wr(input logic [2:0] a, input logic [7:0] d);
        @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'b1};
        @(posedge CLK) WR <= 1'b0;
    endtask : wr
    // Read data stand only in the cycle after the strobe, so sample just after that edge.
    task rd(input logic [2:0] a, input logic [7:0] e);
        @(posedge CLK) {ADDR, RD} <= {a, 1'b1};
        @(posedge CLK) RD <= 1'b0;
        #1 chk("rdata", RDATA, e);
    endtask : rd
    task give_verdict;
        if (fails == 0 && cmp_count > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : give_verdict
    // Bounded wait on a break state level, sampled after each edge has settled.
    task wait_inb(input logic v);
        #1;
        for (i = 0; i < 400 && INB !== v; i++) begin
            @(posedge CLK);
            #1;
        end
        chk("break_state", INB, v);
    endtask : wait_inb
    // Whole run is well under a thousand cycles; the limit leaves ample margin.
    initial begin
        #500000 fails++;
        give_verdict();
    end
    initial begin
        repeat (3) @(posedge CLK);
        RST <= 1'b0;
        for (int a = 0; a < 5; a++) rd(a[2:0], 8'h00);
        foreach (ROWS[r]) begin
            wr(ROWS[r][18:16], ROWS[r][15:8]);
            rd(ROWS[r][18:16], ROWS[r][7:0]);
        end
        wait_inb(1'b1);
        chk("freeze", FRZ, 1'b1);
        chk("vector", VEC, 16'hfffc);
        chk("permit", PERM, 1'b1);
        rd(3'h0, 8'hc0);
        rd(3'h5, 8'h01);
        chk("irq_on", IRQ, 1'b1);
        chk("opcode", OPC, brk_pkg::SOFTWARE_INTERRUPT_OPCODE);
        wr(3'h0, 8'h80);
        @(posedge CLK) RET <= 1'b1;
        wait_inb(1'b0);
        RET <= 1'b0;
        chk("freeze_off", FRZ, 1'b0);
        wr(3'h5, 8'h03);
        rd(3'h5, 8'h00);
        chk("irq", IRQ, 1'b0);
        @(posedge CLK) {STOP_M, TV, MON} <= 3'b111;
        wr(3'h0, 8'hc0);
        wait_inb(1'b1);
        chk("stop_exit", SEXIT, 1'b1);
        @(posedge CLK) STOP_M <= 1'b0;
        #1 chk("watchdog", WOFF, 1'b1);
        chk("vector_mon", VEC, 16'hfefc);
        rd(3'h3, 8'h02);
        wr(3'h3, 8'h00);
        rd(3'h3, 8'h00);
        wr(3'h4, 8'h00);
        rd(3'h4, 8'h00);
        chk("permit_off", PERM, 1'b0);
        wr(3'h0, 8'h80);
        @(posedge CLK) RET <= 1'b1;
        wait_inb(1'b0);
        RET <= 1'b0;
        chk("watchdog_off", WOFF, 1'b0);
        @(posedge CLK) {WAIT_M, TV, MON} <= 3'b100;
        wr(3'h0, 8'hc0);
        wait_inb(1'b1);
        chk("watchdog_no_tv", WOFF, 1'b0);
        chk("vector_norm", VEC, 16'hfffc);
        rd(3'h3, 8'h02);
        wr(3'h0, 8'h80);
        @(posedge CLK) RET <= 1'b1;
        wait_inb(1'b0);
        RET <= 1'b0;
        rd(3'h0, 8'h80);
        give_verdict();
    end
endmodule : address_breakpoint_unit_test
